// ==== common/ext_irq_sel_pkg.sv ====
// package: register map, field layout and pin-group codes for the port selector
package ext_irq_sel_pkg;
    // register indices in the special function register space; the bus
    // carries one aligned word per register, so the byte address is four
    // times the index and the register sits in bits 15:0 of that word
    localparam logic [15:0] ADDR_PAIR01 = 16'hF048;
    localparam logic [15:0] ADDR_PAIR23 = 16'hF04A;
    localparam logic [15:0] ADDR_PAIR45 = 16'hF04C;
    // reset value of every selection register
    localparam logic [15:0] SEL_RESET = 16'h0000;
    // field positions inside one 8-bit line field
    localparam int PIN_LSB = 0;
    localparam int GROUP_LSB = 4;
    localparam int FIELD_W = 8;
    // number of lines served and of selection registers
    localparam int NUM_LINES = 6;
    localparam int NUM_PAIRS = 3;
    // group codes
    localparam logic [3:0] GRP_PORT0 = 4'h0;
    localparam logic [3:0] GRP_XTAL = 4'h1;
    localparam logic [3:0] GRP_PORT2 = 4'h2;
    localparam logic [3:0] GRP_PORT3 = 4'h3;
    localparam logic [3:0] GRP_PORT4 = 4'h4;
    localparam logic [3:0] GRP_PORT5 = 4'h5;
    // number of mapped pins per group
    localparam logic [3:0] PORT0_PINS = 4'h6;
    localparam logic [3:0] XTAL_PINS = 4'h2;
    localparam logic [3:0] PORT2_PINS = 4'h4;
    localparam logic [3:0] FULL_PINS = 4'h8;
    // level given to a line whose code maps to no pin
    localparam logic IDLE_LEVEL = 1'b0;
endpackage : ext_irq_sel_pkg

// ==== design/pin_sync.sv ====
// two-flop synchroniser for a bundle of asynchronous pin levels
`timescale 1ns/1ps
module pin_sync
    import ext_irq_sel_pkg::*;
#(
    parameter int WIDTH = 8
)
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    // first stage, read only by the second stage
    logic [WIDTH-1:0] meta;

    // both stages clear to zero so the lines start idle
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            meta <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta <= async_in;
            sync_out <= meta;
        end
    end
endmodule // pin_sync

// ==== design/line_pin_mux.sv ====
// one line's selector: group and pin code to a single pin level
`timescale 1ns/1ps
module line_pin_mux
    import ext_irq_sel_pkg::*;
(
    input wire logic [7:0] field,
    input wire logic [5:0] port0,
    input wire logic [1:0] xtal,
    input wire logic [3:0] port2,
    input wire logic [7:0] port3,
    input wire logic [7:0] port4,
    input wire logic [7:0] port5,
    output logic level
);
    // codes split out of the field
    logic [3:0] pin_code;
    logic [3:0] group_code;
    assign pin_code = field[PIN_LSB +: 4];
    assign group_code = field[GROUP_LSB +: 4];

    // unmapped codes give the idle level instead of a stray pin
    always_comb
    begin
        level = IDLE_LEVEL;
        case (group_code)
            GRP_PORT0: if (pin_code < PORT0_PINS) level = port0[pin_code[2:0]];
            GRP_XTAL: if (pin_code < XTAL_PINS) level = xtal[pin_code[0]];
            GRP_PORT2: if (pin_code < PORT2_PINS) level = port2[pin_code[1:0]];
            GRP_PORT3: if (pin_code < FULL_PINS) level = port3[pin_code[2:0]];
            GRP_PORT4: if (pin_code < FULL_PINS) level = port4[pin_code[2:0]];
            GRP_PORT5: if (pin_code < FULL_PINS) level = port5[pin_code[2:0]];
            default: level = IDLE_LEVEL;
        endcase
    end
endmodule // line_pin_mux

// ==== design/ext_irq_port_selector.sv ====
// external interrupt port selector: AHB-Lite registers and six pin muxes
`timescale 1ns/1ps
module ext_irq_port_selector
    import ext_irq_sel_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [5:0] port0_pins,
    input wire logic [1:0] crystal_port_bits,
    input wire logic [3:0] port2_pins,
    input wire logic [7:0] port3_pins,
    input wire logic [7:0] port4_pins,
    input wire logic [7:0] port5_pins,
    output logic ext_irq_line_0,
    output logic ext_irq_line_1,
    output logic ext_irq_line_2,
    output logic ext_irq_line_3,
    output logic ext_irq_line_4,
    output logic ext_irq_line_5
);
    // selection registers, one per pair of lines
    logic [15:0] sel_reg [NUM_PAIRS];
    // latched address phase
    logic wr_pend;
    logic [1:0] wr_idx;
    logic [3:0] wr_lanes;
    // synchronised pin levels
    logic [5:0] s_port0;
    logic [1:0] s_xtal;
    logic [3:0] s_port2;
    logic [7:0] s_port3;
    logic [7:0] s_port4;
    logic [7:0] s_port5;
    // mux outputs before the output flops
    logic [NUM_LINES-1:0] mux_level;
    logic [NUM_LINES-1:0] line_q;

    // address decode: which selection register, if any
    logic addr_hit;
    logic [1:0] addr_idx;
    logic [3:0] lane_mask;
    always_comb
    begin
        addr_hit = 1'b1;
        addr_idx = 2'd0;
        // word index of the transfer; each register owns a whole word
        case (haddr[17:2])
            ADDR_PAIR01: addr_idx = 2'd0;
            ADDR_PAIR23: addr_idx = 2'd1;
            ADDR_PAIR45: addr_idx = 2'd2;
            default: addr_hit = 1'b0;
        endcase
        // upper address bits must be clear, or the register would alias
        if (haddr[31:18] != 14'h0000)
            addr_hit = 1'b0;
    end

    // byte lanes touched by the transfer, relative to the register
    always_comb
    begin
        case (hsize)
            // byte lanes 2 and 3 of the word hold nothing
            3'b000: lane_mask = (haddr[1:0] == 2'b00) ? 4'b0001 :
                                (haddr[1:0] == 2'b01) ? 4'b0010 : 4'b0000;
            3'b001: lane_mask = haddr[1] ? 4'b0000 : 4'b0011;
            default: lane_mask = 4'b0011;
        endcase
    end

    // address phase capture; the slave is always ready, zero wait states
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend <= 1'b0;
            wr_idx <= 2'd0;
            wr_lanes <= 4'h0;
        end
        else if (hready)
        begin
            wr_pend <= hsel && htrans[1] && hwrite && addr_hit;
            wr_idx <= addr_idx;
            wr_lanes <= lane_mask;
        end
    end

    // data phase write with byte-lane merge; register lives in bits 15:0
    logic [15:0] wr_half;
    assign wr_half = hwdata[15:0];
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            for (int i = 0; i < NUM_PAIRS; i++)
                sel_reg[i] <= SEL_RESET;
        end
        else if (wr_pend)
        begin
            if (wr_lanes[0])
                sel_reg[wr_idx][7:0] <= wr_half[7:0];
            if (wr_lanes[1])
                sel_reg[wr_idx][15:8] <= wr_half[15:8];
        end
    end

    // read data registered in the address phase, word-lane placed
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata <= 32'h0000_0000;
        else if (hready && hsel && htrans[1])
        begin
            // held until the next accepted transfer, so it stands in the data phase
            if (!hwrite && addr_hit)
                hrdata <= {16'h0000, sel_reg[addr_idx]};
            else
                hrdata <= 32'h0000_0000;
        end
    end

    // no wait states, always OKAY
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // pins come from outside the clock domain
    pin_sync #(.WIDTH(36)) u_sync
    (
        .hclk(hclk),
        .hresetn(hresetn),
        .async_in({port5_pins, port4_pins, port3_pins, port2_pins,
                   crystal_port_bits, port0_pins}),
        .sync_out({s_port5, s_port4, s_port3, s_port2, s_xtal, s_port0})
    );

    // one mux per line; even line uses low byte, odd line high byte
    generate
        for (genvar n = 0; n < NUM_LINES; n++)
        begin : g_line
            line_pin_mux u_mux
            (
                .field(sel_reg[n/2][(n%2)*FIELD_W +: FIELD_W]),
                .port0(s_port0),
                .xtal(s_xtal),
                .port2(s_port2),
                .port3(s_port3),
                .port4(s_port4),
                .port5(s_port5),
                .level(mux_level[n])
            );
        end
    endgenerate

    // outputs straight from flops, idle after reset
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            line_q <= '0;
        else
            line_q <= mux_level;
    end
    assign ext_irq_line_0 = line_q[0];
    assign ext_irq_line_1 = line_q[1];
    assign ext_irq_line_2 = line_q[2];
    assign ext_irq_line_3 = line_q[3];
    assign ext_irq_line_4 = line_q[4];
    assign ext_irq_line_5 = line_q[5];

    // pin to line latency: 2 sync flops plus output flop
    property p_line0_port0;
        @(posedge hclk) disable iff (!hresetn)
        (sel_reg[0][7:0] == 8'h00) [*4] |-> ext_irq_line_0 == $past(port0_pins[0], 3);
    endproperty
    a_line0_port0: assert property (p_line0_port0) else $error("line0 not port0 pin0");

    property p_line1_unmapped;
        @(posedge hclk) disable iff (!hresetn)
        (sel_reg[0][15:12] > 4'h5) |=> !ext_irq_line_1;
    endproperty
    a_line1_unmapped: assert property (p_line1_unmapped) else $error("unmapped not idle");

    property p_word_write;
        @(posedge hclk) disable iff (!hresetn)
        (wr_pend && wr_lanes == 4'b0011) |=> sel_reg[$past(wr_idx)] == $past(wr_half);
    endproperty
    a_word_write: assert property (p_word_write) else $error("word write lost");

    property p_line2_port3;
        @(posedge hclk) disable iff (!hresetn)
        (sel_reg[1][7:0] == 8'h35) [*4] |-> ext_irq_line_2 == $past(port3_pins[5], 3);
    endproperty
    a_line2_port3: assert property (p_line2_port3) else $error("line2 port3 route");

    property p_line3_xtal;
        @(posedge hclk) disable iff (!hresetn)
        (sel_reg[1][15:8] == 8'h11) [*4] |-> ext_irq_line_3 == $past(crystal_port_bits[1], 3);
    endproperty
    a_line3_xtal: assert property (p_line3_xtal) else $error("line3 xtal route");

    property p_line4_port2_gap;
        @(posedge hclk) disable iff (!hresetn)
        (sel_reg[2][7:0] == 8'h24) |=> !ext_irq_line_4;
    endproperty
    a_line4_port2_gap: assert property (p_line4_port2_gap) else $error("port2 pin4 mapped");

    property p_line5_port0_gap;
        @(posedge hclk) disable iff (!hresetn)
        (sel_reg[2][15:8] == 8'h06) |=> !ext_irq_line_5;
    endproperty
    a_line5_port0_gap: assert property (p_line5_port0_gap) else $error("port0 pin6 mapped");

    property p_byte_hi_keeps_lo;
        @(posedge hclk) disable iff (!hresetn)
        (wr_pend && wr_lanes == 4'b0010)
            |=> sel_reg[$past(wr_idx)][7:0] == $past(sel_reg[wr_idx][7:0]);
    endproperty
    a_byte_hi_keeps_lo: assert property (p_byte_hi_keeps_lo) else $error("byte write spill");

    // a miss on the address map must never reach a register
    property p_miss_no_write;
        @(posedge hclk) disable iff (!hresetn)
        (hready && hsel && htrans[1] && hwrite && !addr_hit) |=> !wr_pend;
    endproperty
    a_miss_no_write: assert property (p_miss_no_write) else $error("miss wrote");

    // read data of a hit is the register word seen at the address phase
    property p_read_data;
        @(posedge hclk) disable iff (!hresetn)
        (hready && hsel && htrans[1] && !hwrite && addr_hit)
            |=> hrdata[15:0] == $past(sel_reg[addr_idx]) && hrdata[31:16] == 16'h0000;
    endproperty
    a_read_data: assert property (p_read_data) else $error("read data wrong");

    // without a data phase write the selections hold
    property p_hold_without_write;
        @(posedge hclk) disable iff (!hresetn)
        !wr_pend |=> sel_reg[0] == $past(sel_reg[0]) && sel_reg[1] == $past(sel_reg[1])
            && sel_reg[2] == $past(sel_reg[2]);
    endproperty
    a_hold_without_write: assert property (p_hold_without_write) else $error("sel drift");

    // zero wait states and an OKAY answer on every cycle
    property p_bus_okay;
        @(posedge hclk) disable iff (!hresetn)
        hreadyout && !hresp;
    endproperty
    a_bus_okay: assert property (p_bus_okay) else $error("bus not okay");
endmodule // ext_irq_port_selector

// ==== sim/port_pin_model.sv ====
// partner model: the six port groups, moving to fresh random levels on request
`timescale 1ns/1ps
module port_pin_model
#(
    parameter int SEED = 60019
)
(
    input wire logic hclk,
    input wire logic change,
    output logic [35:0] pins
);
    // private stream, so pin levels do not shift with bench draws
    int seed = SEED;
    // levels move only on request, giving the synchroniser time to settle
    always @(posedge hclk)
    begin
        if (change)
        begin
            pins <= 36'({$random(seed), $random(seed)});
        end
    end
    // quiet start before the first request
    initial pins = 36'h0;
endmodule // port_pin_model

// ==== sim/testbench.sv ====
// self-checking bench for the port selector: bus tasks, mirror and sweeps
`timescale 1ns/1ps
module testbench
    import ext_irq_sel_pkg::*;
;
    logic hclk, hresetn, hsel, hwrite, change, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [35:0] pins; // p0 5:0, xtal 7:6, p2 11:8, p3/p4/p5 from bit 12
    logic [5:0] lines;
    logic [15:0] sel [3]; // mirror of the three selection registers
    int num_errors, num_checks, seed, g, p, r;
    logic [15:0] v;
    logic [31:0] rdw;

    ext_irq_port_selector u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .port0_pins(pins[5:0]),
        .crystal_port_bits(pins[7:6]), .port2_pins(pins[11:8]), .port3_pins(pins[19:12]),
        .port4_pins(pins[27:20]), .port5_pins(pins[35:28]), .ext_irq_line_0(lines[0]),
        .ext_irq_line_1(lines[1]), .ext_irq_line_2(lines[2]), .ext_irq_line_3(lines[3]),
        .ext_irq_line_4(lines[4]), .ext_irq_line_5(lines[5]));
    port_pin_model u_pins (.hclk(hclk), .change(change), .pins(pins));

    // 125 MHz system clock
    always #4 hclk = ~hclk;

    // expected level of one line from its field and the pin levels
    function automatic logic exp_level(logic [7:0] f, logic [35:0] pv);
        logic [3:0] n;
        n = f[3:0];
        case (f[7:4])
            GRP_PORT0: return (n < PORT0_PINS) ? pv[n] : IDLE_LEVEL;
            GRP_XTAL: return (n < XTAL_PINS) ? pv[6 + n] : IDLE_LEVEL;
            GRP_PORT2: return (n < PORT2_PINS) ? pv[8 + n] : IDLE_LEVEL;
            GRP_PORT3: return (n < FULL_PINS) ? pv[12 + n] : IDLE_LEVEL;
            GRP_PORT4: return (n < FULL_PINS) ? pv[20 + n] : IDLE_LEVEL;
            GRP_PORT5: return (n < FULL_PINS) ? pv[28 + n] : IDLE_LEVEL;
            default: return IDLE_LEVEL; // unmapped groups stay quiet
        endcase
    endfunction

    // byte address of a register: one aligned word per index
    function automatic logic [31:0] reg_addr(int ri);
        logic [15:0] idx;
        idx = (ri == 0) ? ADDR_PAIR01 : (ri == 1) ? ADDR_PAIR23 : ADDR_PAIR45;
        return {14'h0000, idx, 2'b00};
    endfunction

    // only mapped group and pin pairs, as software must keep to
    function automatic logic [7:0] mk_field(int g, int p);
        int n;
        n = (g == 0) ? int'(PORT0_PINS) : (g == 1) ? int'(XTAL_PINS) :
            (g == 2) ? int'(PORT2_PINS) : int'(FULL_PINS);
        return {4'(g), 4'(p % n)};
    endfunction

    // verdict and end of run
    task report_and_stop;
        if (num_errors == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // one comparison, counted
    task check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("Error %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    // bounded wait for hready high at a rising edge
    task wait_ready;
        int n;
        n = 0;
        do
        begin
            @(posedge hclk);
            n++;
        end
        while (hreadyout !== 1'b1 && n < 100);
        if (n >= 100)
        begin
            num_errors++;
            report_and_stop;
        end
    endtask

    // one single transfer: address phase, then data phase
    task bus(input logic w, input logic [31:0] a, input logic [2:0] s, input logic [31:0] d,
        output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= w;
        hsize <= s;
        wait_ready();
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= d;
        wait_ready();
        rd = hrdata;
        check(32'(hresp), 32'h0);
    endtask

    // whole-word register write; lines here carry no enable or pending flag,
    // so the disable-before and clear-after steps fall to the edge logic
    task wr(input int ri, input logic [15:0] val);
        logic [31:0] rd;
        bus(1'b1, reg_addr(ri), 3'd2, 32'(val), rd);
        sel[ri] = val;
    endtask

    // new pin levels, settle, then every line and all three words against the mirror
    task check_all;
        int k;
        logic [31:0] rd;
        change <= 1'b1;
        @(posedge hclk);
        change <= 1'b0;
        repeat (6) @(posedge hclk);
        for (k = 0; k < 6; k++)
            check(32'(lines[k]), 32'(exp_level(sel[k / 2][8 * (k % 2) +: 8], pins)));
        for (k = 0; k < 3; k++)
        begin
            bus(1'b0, reg_addr(k), 3'd2, 32'h0, rd);
            check(rd, {16'h0000, sel[k]});
        end
    endtask

    // main sequence
    initial
    begin
        hclk = 0;
        hresetn = 0;
        {hsel, hwrite, change, htrans, hsize, haddr, hwdata} = '0;
        num_errors = 0;
        num_checks = 0;
        seed = 60019;
        sel = '{3{SEL_RESET}};
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        check_all();
        // every mapped group and pin code, shifted so each line sees its own code
        for (g = 0; g < 6; g++)
            for (p = 0; p < 9; p++)
            begin
                for (r = 0; r < 3; r++)
                    wr(r, {mk_field(g, p + 2 * r + 1), mk_field(g, p + 2 * r)});
                check_all();
            end
        // corner cases: second crystal bit, top pins of port2, port4 and port5
        wr(0, 16'h1101);
        wr(1, 16'h5735);
        wr(2, 16'h4723);
        check_all();
        // random mapped fields
        repeat (100)
        begin
            r = {$random(seed)} % 3;
            v[15:8] = mk_field({$random(seed)} % 6, {$random(seed)} % 8);
            v[7:0] = mk_field({$random(seed)} % 6, {$random(seed)} % 8);
            wr(r, v);
            check_all();
        end
        // unmapped word index: write ignored, reads zero
        bus(1'b1, {14'h0000, 16'hF04E, 2'b00}, 3'd2, 32'h0000_FFFF, rdw);
        bus(1'b0, {14'h0000, 16'hF04E, 2'b00}, 3'd2, 32'h0, rdw);
        check(rdw, 32'h0);
        check_all();
        // reset in mid-run clears every selection
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        sel = '{3{SEL_RESET}};
        check_all();
        report_and_stop();
    end
endmodule // testbench
